// ---- rtl/dpm_mgmt_slave.sv ----
/*
 * Dual-port serial management slave: frame decoder, two 32 x 16 register
 * blocks, read shifter and simultaneous-write mirroring.
 * Assumes mdc and mdio_in are asynchronous pins; clk is far faster than mdc.
 */
//
// Contract
// [RULE1] Station keeps mdc at or below 25 MHz
// [RULE2] Respond only when device address matches
// [RULE3] Station sends 32 ones for initial preamble
// [RULE4] Ignore frames until full preamble after reset
// [RULE5] Errors in start/opcode/turnaround need new preamble
// [RULE6] Start code must be zero then one
// [RULE7] Frame: op, phy, reg, turnaround, 16 data
// [RULE8] Read: release first turnaround, drive zero, data
// [RULE9] Write: station drives turnaround and data
// [RULE10] Station resends preamble after possible errors
// [RULE11] Status register bit 6 reports preamble suppression
// [RULE12] Station leaves one idle bit between frames
// [RULE13] Thirty-two 16-bit registers per port
// [RULE14] Port A bypass bit 15 enables simultaneous write
// [RULE15] Port A writes then update both ports
// [RULE16] Reads stay per port
// [RULE17] Driver disabled on mismatch or write
// [RULE18] Sample on rising mdc, change after it
`timescale 1ns/1ps
`include "dpm_cfg.svh"
module dpm_mgmt_slave #(
	parameter logic [4:0] PHYAD_A = `DPM_PHYAD_A_DEF,
	parameter logic [4:0] PHYAD_B = `DPM_PHYAD_B_DEF
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic mdc,
	input  wire logic mdio_in,
	output logic      mdio_out,
	output logic      mdio_oe_n,
	output logic      synced,
	output logic      sim_write_en
);
	logic [2:0]  mdc_s;
	logic [1:0]  mdio_s;
	logic        rise;
	logic        fall;
	logic        bit_in;
	dpm_pkg::dpm_state_t state;
	logic [5:0]  ones;
	logic [4:0]  cnt;
	logic [15:0] sh;
	logic        hit_a;
	logic        hit_b;
	logic        is_read;
	logic [15:0] rd_sh;
	logic        drive;
	logic [15:0] regs_a [`DPM_NREGS];
	logic [15:0] regs_b [`DPM_NREGS];
	dpm_pkg::dpm_hdr_t   hdr;
	dpm_pkg::dpm_wreq_t  wreq;
	logic [15:0] next_sh;
	logic        sim_on;

	// Pin synchronisers; edges taken after the second stage
	always_ff @(posedge clk)
	begin
		mdc_s  <= {mdc_s[1:0], mdc};
		mdio_s <= {mdio_s[0], mdio_in};
	end
	assign rise   = mdc_s[1] & ~mdc_s[2];
	assign fall   = ~mdc_s[1] & mdc_s[2];
	assign bit_in = mdio_s[1];                                 // [RULE18]
	assign next_sh = {sh[14:0], bit_in};
	assign hdr     = next_sh;
	assign sim_on  = regs_a[`DPM_REG_BYPASS][`DPM_BIT_SIM_WRITE];  // [RULE14]

	// Frame state machine
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state   <= dpm_pkg::DPM_HUNT;
			ones    <= 6'h00;
			cnt     <= 5'h00;
			sh      <= 16'h0000;
			hit_a   <= 1'b0;
			hit_b   <= 1'b0;
			is_read <= 1'b0;
		end
		else if (rise)
		begin
			sh <= next_sh;
			case (state)
				dpm_pkg::DPM_HUNT:
				begin
					// Count contiguous ones until preamble complete
					if (!bit_in)
						ones <= 6'h00;
					else if (ones == `DPM_PREAMBLE_LEN - 6'h01)
						state <= dpm_pkg::DPM_IDLE;           // [RULE4]
					else
						ones <= ones + 6'h01;
				end
				dpm_pkg::DPM_IDLE:
				begin
					// First zero is start bit one
					if (!bit_in)
					begin
						state <= dpm_pkg::DPM_HDR;
						cnt   <= 5'h01;
					end
				end
				dpm_pkg::DPM_HDR:
				begin
					cnt <= cnt + 5'h01;
					if (cnt == `DPM_CNT_START && next_sh[1:0] != `DPM_START_CODE)
					begin
						state <= dpm_pkg::DPM_HUNT;             // [RULE6] [RULE5]
						ones  <= 6'h00;
					end
					else if (cnt == `DPM_CNT_OP && next_sh[1:0] != `DPM_OP_READ
						&& next_sh[1:0] != `DPM_OP_WRITE)
					begin
						state <= dpm_pkg::DPM_HUNT;             // [RULE5]
						ones  <= 6'h00;
					end
					else if (cnt == `DPM_HDR_BITS - 5'h01)
					begin
						// Header through phy/reg; first turnaround bit next
						is_read <= (next_sh[11:10] == `DPM_OP_READ);
						hit_a   <= (next_sh[9:5] == PHYAD_A);   // [RULE2]
						hit_b   <= (next_sh[9:5] == PHYAD_B);   // [RULE2]
					end
					else if (cnt == `DPM_HDR_BITS)
					begin
						cnt <= 5'h00;
						// First turnaround bit must be high for both kinds
						if (!is_read && !bit_in)
						begin
							state <= dpm_pkg::DPM_HUNT;         // [RULE5]
							ones  <= 6'h00;
						end
						else if (is_read && !bit_in)
						begin
							state <= dpm_pkg::DPM_HUNT;         // [RULE5]
							ones  <= 6'h00;
						end
						else
							state <= dpm_pkg::DPM_DATA;         // [RULE7]
					end
				end
				dpm_pkg::DPM_DATA:
				begin
					cnt <= cnt + 5'h01;
					// Write turnaround must be 1,0; checked on its second bit
					if (cnt == 5'h00 && !is_read && hdr.ta != `DPM_TA_WRITE)
					begin
						state <= dpm_pkg::DPM_HUNT;             // [RULE5]
						ones  <= 6'h00;
					end
					else if (cnt == `DPM_DATA_CNT)
						state <= dpm_pkg::DPM_IDLE;            // [RULE12]
				end
				default:
					state <= dpm_pkg::DPM_HUNT;
			endcase
		end
	end

	// Captured register address for the active frame
	logic [4:0] raddr;
	always_ff @(posedge clk)
	begin
		if (reset)
			raddr <= 5'h00;
		else if (rise && state == dpm_pkg::DPM_HDR && cnt == `DPM_HDR_BITS - 5'h01)
			raddr <= next_sh[4:0];
	end

	// Write request at last data bit; mirror to B when enabled
	always_comb
	begin
		wreq.addr = raddr;
		wreq.data = next_sh;
		wreq.we_a = rise && state == dpm_pkg::DPM_DATA && cnt == `DPM_DATA_CNT
			&& !is_read && hit_a;
		wreq.we_b = rise && state == dpm_pkg::DPM_DATA && cnt == `DPM_DATA_CNT
			&& !is_read && (hit_b || (hit_a && sim_on));           // [RULE15]
	end

	// Register blocks; status bit 6 is read-only one
	genvar gi;
	generate
		for (gi = 0; gi < `DPM_NREGS; gi++)
		begin : g_regs
			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					regs_a[gi] <= (gi == `DPM_REG_STATUS) ? `DPM_STATUS_RESET : 16'h0000; // [RULE11]
					regs_b[gi] <= (gi == `DPM_REG_STATUS) ? `DPM_STATUS_RESET : 16'h0000;
				end
				else
				begin
					if (wreq.we_a && wreq.addr == gi && gi != `DPM_REG_STATUS)
						regs_a[gi] <= wreq.data;                    // [RULE13] [RULE14]
					if (wreq.we_b && wreq.addr == gi && gi != `DPM_REG_STATUS)
						regs_b[gi] <= wreq.data;                    // [RULE15]
				end
			end
		end
	endgenerate

	// Read driver: load on turnaround, change after falling mdc
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			drive <= 1'b0;
			rd_sh <= 16'h0000;
		end
		else if (rise && state == dpm_pkg::DPM_HDR && cnt == `DPM_HDR_BITS
			&& is_read && bit_in && (hit_a || hit_b))
		begin
			drive <= 1'b1;                                  // [RULE8]
			rd_sh <= hit_a ? regs_a[raddr] : regs_b[raddr];  // [RULE16]
		end
		else if (state != dpm_pkg::DPM_HDR && state != dpm_pkg::DPM_DATA)
			drive <= 1'b0;                                  // [RULE17]
		else if (fall && state == dpm_pkg::DPM_DATA && cnt != 5'h00)
			rd_sh <= {rd_sh[14:0], 1'b0};
	end

	// Outputs from flip-flops; zero during second turnaround bit
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mdio_out  <= 1'b1;
			mdio_oe_n <= 1'b1;
		end
		else if (fall || !drive)
		begin
			mdio_oe_n <= ~(drive && state == dpm_pkg::DPM_DATA);  // [RULE17] [RULE18]
			mdio_out  <= (state == dpm_pkg::DPM_DATA && cnt == 5'h00) ? 1'b0
				: rd_sh[15];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			synced       <= 1'b0;
			sim_write_en <= 1'b0;
		end
		else
		begin
			synced       <= (state != dpm_pkg::DPM_HUNT);
			sim_write_en <= sim_on;
		end
	end
endmodule

// ---- rtl/dpm_cfg.svh ----
/*
 * Constants for the dual-port serial management slave: frame field codes,
 * register indices and bit positions.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH
`define DPM_PREAMBLE_LEN 6'h20
`define DPM_START_CODE 2'h1
`define DPM_OP_READ 2'h2
`define DPM_OP_WRITE 2'h1
`define DPM_TA_WRITE 2'h2
`define DPM_ADDR_BITS 5
`define DPM_DATA_BITS 16
`define DPM_NREGS 32
`define DPM_REG_STATUS 5'h01
`define DPM_REG_BYPASS 5'h17
`define DPM_BIT_PRE_SUPP 6
`define DPM_BIT_SIM_WRITE 15
`define DPM_CNT_START 5'h01
`define DPM_CNT_OP 5'h03
`define DPM_HDR_BITS 5'h0e
`define DPM_DATA_CNT 5'h10
`define DPM_PHYAD_A_DEF 5'h01
`define DPM_PHYAD_B_DEF 5'h02
`define DPM_STATUS_RESET 16'h7849
`endif

// ---- rtl/dpm_pkg.sv ----
/*
 * Types for the dual-port serial management slave.
 * Assumes dpm_cfg.svh is on the include path.
 */
`include "dpm_cfg.svh"
package dpm_pkg;
	typedef enum logic [4:0] {
		DPM_HUNT  = 5'h01,
		DPM_IDLE  = 5'h02,
		DPM_HDR   = 5'h04,
		DPM_DATA  = 5'h08,
		DPM_SKIP  = 5'h10
	} dpm_state_t;

	// Decoded frame header
	typedef struct packed {
		logic [1:0] start;
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] reg_addr;
		logic [1:0] ta;
	} dpm_hdr_t;

	// Register-file write request towards both ports
	typedef struct packed {
		logic        we_a;
		logic        we_b;
		logic [4:0]  addr;
		logic [15:0] data;
	} dpm_wreq_t;
endpackage

// ---- verification/dpm_mgmt_properties.sv ----
/* Port properties of the management slave.
   Assumes bind from the bench, about 8 clk per mdc bit. */
`timescale 1ns/1ps
module dpm_mgmt_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	input wire logic synced,
	input wire logic sim_write_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	reset_quiet_a: assert property ($fell(reset) |-> mdio_oe_n && !synced && !sim_write_en)
		else $error("outputs not idle after reset");
	drive_synced_a: assert property (!mdio_oe_n |-> synced)
		else $error("driving while unsynced");
	ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
		else $error("first driven bit not zero");
	drive_span_a: assert property ($fell(mdio_oe_n) |=> !mdio_oe_n [*8])
		else $error("drive cut short");
	drive_end_a: assert property ($fell(mdio_oe_n) |-> ##[120:150] mdio_oe_n)
		else $error("drive not released after data");
	change_late_a: assert property (!mdio_oe_n && $changed(mdio_out) |-> !$past(mdc, 3))
		else $error("data changed near rising mdc");
	idle_gap_a: assert property ($rose(mdio_oe_n) |=> mdio_oe_n [*8])
		else $error("drive restarted at once");
	lose_sync_a: assert property ($fell(synced) |-> mdio_oe_n)
		else $error("sync lost while driving");
	mirror_on_a: assert property ($rose(sim_write_en) |-> synced && mdio_oe_n)
		else $error("mirror bit set without write");
	cover property ($fell(mdio_oe_n));
	cover property ($rose(sim_write_en));
	cover property ($fell(synced));
endmodule

// ---- verification/dpm_station.sv ----
/* Station model: makes mdc, drives or releases the data line.
   Assumes a pull-up on the line and clk at 50 MHz. */
`timescale 1ns/1ps
module dpm_station (
	input wire logic clk,
	output logic     mdc,
	output wire logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_n
);
	logic        drv = 1'b0;
	logic        dval = 1'b1;
	logic [17:0] sh;
	initial mdc = 1'b0;
	// Pull-up when nobody drives
	assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? dval : 1'b1);
	// 160 ns bit, change at fall, sample at rise
	task automatic xfer(input logic [63:0] v, input int n, input logic d);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge clk);
			mdc <= 1'b0;
			drv <= d;
			dval <= v[i];
			repeat (4) @(posedge clk);
			mdc <= 1'b1;
			sh = {sh[16:0], mdio_in};
			repeat (3) @(posedge clk);
		end
	endtask
	// Released ones
	task automatic pre(input int n);
		xfer('1, n, 1'b0);
	endtask
	// Header, own turnaround and data on writes, one idle bit
	task automatic frame(input logic [13:0] h, input logic [17:0] w, input logic rd);
		logic [17:0] r;
		xfer(64'(h), 14, 1'b1);
		xfer(64'(w), 18, !rd);
		r = sh;
		xfer(64'h1, 1, 1'b0);
		sh = r;
	endtask
endmodule

// ---- verification/dpm_mgmt_slave_tb_top.sv ----
/* Bench for the management slave, rows of frames then hand cases.
   Assumes dpm_cfg.svh on the include path, phy addresses 1 and 2. */
`timescale 1ns/1ps
`include "dpm_cfg.svh"
module dpm_mgmt_slave_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	wire  mdc, mdio_in, mdio_out, mdio_oe_n, synced, sim_write_en;
	int   error_cnt = 0;
	int   checks = 0;
	int   cyc = 0;
	typedef struct { logic [13:0] h; logic [17:0] w; logic rd; } dpm_row_t;
	dpm_row_t rows[$] = '{
		'{14'h1423, 18'h21234, 0}, '{14'h1823, 18'h21234, 1}, '{14'h1843, 18'h20000, 1},
		'{14'h1821, 18'h27849, 1}, '{14'h1421, 18'h25555, 0}, '{14'h1821, 18'h27849, 1},
		'{14'h14a3, 18'h2ffff, 0}, '{14'h1823, 18'h21234, 1}, '{14'h18a3, 18'h3ffff, 1},
		'{14'h1437, 18'h28000, 0}, '{14'h1424, 18'h2abcd, 0}, '{14'h1844, 18'h2abcd, 1},
		'{14'h1445, 18'h20111, 0}, '{14'h1825, 18'h20000, 1}, '{14'h1437, 18'h20000, 0},
		'{14'h1426, 18'h20f0f, 0}, '{14'h1846, 18'h20000, 1}, '{14'h145f, 18'h2fedc, 0},
		'{14'h185f, 18'h2fedc, 1}};
	logic [13:0] bad[3] = '{14'h0423, 14'h1c23, 14'h1423};
	initial forever #10 clk = ~clk;
	dpm_mgmt_slave dpm_mgmt_slave_inst (.clk, .reset, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
		.synced, .sim_write_en);
	dpm_station dpm_station_inst (.clk, .mdc, .mdio_in, .mdio_out, .mdio_oe_n);
	task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] s);
		checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		dpm_station_inst.pre(31);
		dpm_station_inst.frame(14'h1821, 18'h0, 1);
		chk("early read", 18'h3ffff, dpm_station_inst.sh);
		dpm_station_inst.pre(32);
		repeat (4) @(posedge clk);
		chk("synced", 18'h1, 18'(synced));
		foreach (rows[i])
		begin
			dpm_station_inst.frame(rows[i].h, rows[i].w, rows[i].rd);
			chk("frame", rows[i].w, dpm_station_inst.sh);
		end
		foreach (bad[i])
		begin
			dpm_station_inst.frame(bad[i], {(i == 2) ? 2'h3 : 2'h2, 16'h0}, 0);
			chk("lost sync", 18'h0, 18'(synced));
			dpm_station_inst.frame(14'h1823, 18'h0, 1);
			chk("no reply", 18'h3ffff, dpm_station_inst.sh);
			dpm_station_inst.pre(32);
		end
		dpm_station_inst.frame(14'h1437, 18'h28000, 0);
		repeat (4) @(posedge clk);
		chk("mirror on", 18'h1, 18'(sim_write_en));
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("reset", 18'h0, 18'({sim_write_en, synced}));
		dpm_station_inst.frame(14'h1821, 18'h0, 1);
		chk("reset no reply", 18'h3ffff, dpm_station_inst.sh);
		dpm_station_inst.pre(32);
		dpm_station_inst.frame(14'h1837, 18'h0, 1);
		chk("reset bypass", 18'h20000, dpm_station_inst.sh);
		end_sim();
	end
endmodule
bind dpm_mgmt_slave dpm_mgmt_properties dpm_mgmt_properties_inst (.clk, .reset, .mdc, .mdio_in,
	.mdio_out, .mdio_oe_n, .synced, .sim_write_en);
